// ==== address_relocation_unit.sv ====
// top of the address relocation and protection unit: apb registers,
// bank selection, two-stage translation pipeline, abort reporting
// assumes the core and bus share CLK_SYS and no back-pressure
//
// Functional notes
// - when enabled, processor addresses are virtual and relocated via a page pair
// - eight 4K-word pages, each relocated through its own pair
// - page length from one to 128 blocks of 32 words
// - a page may start on any 32-word boundary
// - references beyond the allocated part of a short page abort
// - key zero marks the page nonresident; every reference aborts
// - key two allows reads and fetches, aborts writes
// - key six allows reads and writes
// - two banks of eight pairs, privileged and unprivileged
// - bank from current mode, or previous mode when requested
// - mode 00 privileged, 11 unprivileged, others abort while relocation is enabled
// - base and descriptor are always used together per page
// - a reference never maps through the other mode's bank
// - every base and descriptor register has its own bus address
// - an aborted reference issues no bus transfer
// - all management aborts report trap vector octal 250
// - access key in descriptor bits 2:1 with four codes
// - base register holds a twelve-bit base in 32-word blocks
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module address_relocation_unit
    import relocation_pkg::*;
(
    input wire logic CLK_SYS, // system clock, 20 MHz
    input wire logic RST, // async reset, active high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [11:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error
    input wire relocation_pkg::cpu_req_t CPU_REQ, // core reference
    output relocation_pkg::bus_req_t BUS_REQ, // physical transfer
    output logic ABORT, // reference aborted, pulse
    output logic [8:0] TRAP_VECTOR // vector for the abort
);
    import relocation_pkg::*;

    ////////////////////////////////////////////////////////////////
    // apb decode
    wire logic apb_access = PSEL && PENABLE;
    wire logic aligned = (PADDR[1:0] == 2'h0);
    wire logic hit_base = aligned && (PADDR[11:6] == BANK_BASE);
    wire logic hit_desc = aligned && (PADDR[11:6] == BANK_DESC);
    wire logic hit_ctrl = (PADDR == OFS_CTRL);
    wire logic hit_stat = (PADDR == OFS_STAT);
    wire logic hit_any = hit_base || hit_desc || hit_ctrl || hit_stat;
    wire logic [IDX_W-1:0] sw_idx = PADDR[5:2];
    // one wait state: the first access cycle moves the word into a
    // register, the second answers; writes land on the answering edge
    logic ack_reg;
    wire logic ack_next = apb_access && !ack_reg;
    wire logic apb_wr = apb_access && PWRITE && ack_reg;

    wire logic wr_base = apb_wr && hit_base;
    wire logic wr_desc = apb_wr && hit_desc;
    wire logic wr_ctrl = apb_wr && hit_ctrl;
    wire logic wr_stat = apb_wr && hit_stat;

    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [CAUSE_W-1:0] stat_reg;
    logic [CAUSE_W-1:0] stat_next;
    logic [IDX_W-1:0] stat_page_reg;
    logic [IDX_W-1:0] stat_page_next;

    ////////////////////////////////////////////////////////////////
    // stage 0: bank and page selection
    // previous mode on request
    wire logic [1:0] mode_sel =
        CPU_REQ.use_prev ? CPU_REQ.prev_mode : CPU_REQ.cur_mode;
    wire logic mode_priv = (mode_sel == MODE_PRIV);
    wire logic mode_unpriv = (mode_sel == MODE_UNPRIV);
    wire logic mode_ok = mode_priv || mode_unpriv;
    // bank bit follows the mode only
    wire logic [IDX_W-1:0] tr_idx = {mode_unpriv, CPU_REQ.vaddr[15:13]};

    logic s1_valid_reg;
    logic s1_write_reg;
    logic s1_mode_ok_reg;
    logic s1_reloc_reg;
    logic [IDX_W-1:0] s1_idx_reg;
    logic [VA_W-1:0] s1_vaddr_reg;

    logic [BASE_W-1:0] sw_base;
    logic [DESC_W-1:0] sw_desc;
    logic [BASE_W-1:0] tr_base;
    logic [DESC_W-1:0] tr_desc;
    logic [PA_W-1:0] reloc_addr;
    logic [CAUSE_W-1:0] cause;

    page_reg_mem u_mem (
        .clk(CLK_SYS),
        .rst(RST),
        .wr_base(wr_base),
        .wr_desc(wr_desc),
        .wr_idx(sw_idx),
        .wr_data(PWDATA[DESC_W-1:0]),
        .sw_idx(sw_idx),
        .sw_base(sw_base),
        .sw_desc(sw_desc),
        .tr_idx(tr_idx),
        .tr_base(tr_base),
        .tr_desc(tr_desc)
    );

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s1_valid_reg <= 1'b0;
            s1_write_reg <= 1'b0;
            s1_mode_ok_reg <= 1'b0;
            s1_reloc_reg <= 1'b0;
            s1_idx_reg <= '0;
            s1_vaddr_reg <= '0;
        end else begin
            s1_valid_reg <= CPU_REQ.valid;
            s1_write_reg <= CPU_REQ.write;
            s1_mode_ok_reg <= mode_ok;
            s1_reloc_reg <= ctrl_reg[CTRL_EN];
            s1_idx_reg <= tr_idx;
            s1_vaddr_reg <= CPU_REQ.vaddr;
        end
    end

    ////////////////////////////////////////////////////////////////
    // stage 1: relocation and checks
    page_check u_check (
        .base(tr_base),
        .desc(tr_desc),
        .vaddr(s1_vaddr_reg),
        .write(s1_write_reg),
        .mode_ok(s1_mode_ok_reg),
        .paddr(reloc_addr),
        .cause(cause)
    );

    // without relocation the top 4K words map onto the i/o page
    wire logic io_page = (s1_vaddr_reg[15:13] == IO_PAGE);
    wire logic [PA_W-1:0] direct_addr =
        {io_page ? IO_EXT : 2'h0, s1_vaddr_reg};
    wire logic [CAUSE_W-1:0] eff_cause =
        s1_reloc_reg ? cause : CAUSE_W'(0);
    wire logic [PA_W-1:0] phys = s1_reloc_reg ? reloc_addr : direct_addr;
    wire logic abort_now = s1_valid_reg && (eff_cause != '0);
    // aborted references stay off the bus
    wire logic pass_now = s1_valid_reg && (eff_cause == '0);

    bus_req_t bus_reg;
    bus_req_t bus_next;
    logic abort_reg;
    logic [8:0] vec_reg;

    always_comb begin
        bus_next.valid = pass_now;
        bus_next.write = s1_write_reg;
        bus_next.paddr = phys;
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            bus_reg <= '0;
            abort_reg <= 1'b0;
            vec_reg <= '0;
        end else begin
            bus_reg <= bus_next;
            abort_reg <= abort_now;
            vec_reg <= abort_now ? TRAP_VEC : 9'h000;
        end
    end

    assign BUS_REQ = bus_reg;
    assign ABORT = abort_reg;
    assign TRAP_VECTOR = vec_reg;

    ////////////////////////////////////////////////////////////////
    // control and sticky status; a new abort wins over a clear
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = RESET_WORD;
            ctrl_next[CTRL_EN] = PWDATA[CTRL_EN];
        end
        stat_next = stat_reg;
        if (wr_stat) begin
            stat_next = stat_reg & ~PWDATA[CAUSE_W-1:0];
        end
        stat_next = stat_next | (abort_now ? eff_cause : CAUSE_W'(0));
        stat_page_next = abort_now ? s1_idx_reg : stat_page_reg;
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctrl_reg <= RESET_WORD;
            stat_reg <= '0;
            stat_page_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
            stat_page_reg <= stat_page_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read mux; pair data was fetched during the setup cycle
    wire logic [31:0] rd_base = 32'(sw_base);
    wire logic [31:0] rd_desc = 32'(sw_desc);
    wire logic [31:0] rd_stat = 32'({stat_page_reg, stat_reg});
    wire logic [31:0] rd_data =
        hit_base ? rd_base :
        hit_desc ? rd_desc :
        hit_ctrl ? ctrl_reg :
        hit_stat ? rd_stat : RESET_WORD;

    wire logic [31:0] prdata_next = (ack_next && !PWRITE) ? rd_data : RESET_WORD;
    logic [31:0] prdata_reg;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ack_reg <= 1'b0;
            prdata_reg <= RESET_WORD;
        end else begin
            ack_reg <= ack_next;
            prdata_reg <= prdata_next;
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = ack_reg;
    assign PSLVERR = apb_access && ack_reg && !hit_any;
endmodule
`default_nettype wire

// ==== relocation_pkg.sv ====
// constants, field layouts and carriers for the address relocation unit
// assumes one system clock; shared by the top and both leaf modules
package relocation_pkg;
    localparam int VA_W = 16;
    localparam int PA_W = 18;
    localparam int BASE_W = 12;
    localparam int DESC_W = 16;
    localparam int IDX_W = 4;
    localparam int NENT = 16;
    localparam int BLK_W = 7;
    localparam int DISP_W = 13;
    localparam int BLK_SHIFT = 6;
    localparam int CAUSE_W = 4;

    // register byte offsets on the apb bus
    localparam logic [11:0] OFS_BASE = 12'h000;
    localparam logic [11:0] OFS_DESC = 12'h040;
    localparam logic [11:0] OFS_CTRL = 12'h080;
    localparam logic [11:0] OFS_STAT = 12'h084;
    localparam logic [5:0] BANK_BASE = 6'h00;
    localparam logic [5:0] BANK_DESC = 6'h01;

    // descriptor fields
    localparam int KEY_LO = 1;
    localparam int ED_BIT = 3;
    localparam int LEN_LO = 8;
    localparam logic [15:0] DESC_WMASK = 16'h7f0e;
    localparam logic [1:0] KEY_NONRES = 2'h0;
    localparam logic [1:0] KEY_RO = 2'h1;
    localparam logic [1:0] KEY_UNUSED = 2'h2;
    localparam logic [1:0] KEY_RW = 2'h3;

    // processor mode codes
    localparam logic [1:0] MODE_PRIV = 2'h0;
    localparam logic [1:0] MODE_UNPRIV = 2'h3;

    // abort cause bits
    localparam int CAUSE_LEN = 0;
    localparam int CAUSE_ACCESS = 1;
    localparam int CAUSE_NONRES = 2;
    localparam int CAUSE_MODE = 3;

    // trap vector, octal 250
    localparam logic [8:0] TRAP_VEC = 9'h0a8;
    localparam logic [2:0] IO_PAGE = 3'h7;
    localparam logic [1:0] IO_EXT = 2'h3;
    localparam int CTRL_EN = 0;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] cur_mode;
        logic [1:0] prev_mode;
        logic use_prev;
        logic [15:0] vaddr;
    } cpu_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [17:0] paddr;
    } bus_req_t;
endpackage

// ==== page_reg_mem.sv ====
// storage for sixteen page register pairs (eight per mode bank)
// assumes one clock; writes and reads sample on the rising edge
`timescale 1ns/100ps
`default_nettype none
module page_reg_mem
    import relocation_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic wr_base, // write a base register
    input wire logic wr_desc, // write a descriptor register
    input wire logic [IDX_W-1:0] wr_idx, // entry written
    input wire logic [DESC_W-1:0] wr_data, // write data, descriptor bits masked on store
    input wire logic [IDX_W-1:0] sw_idx, // software read entry
    output logic [BASE_W-1:0] sw_base, // software read base
    output logic [DESC_W-1:0] sw_desc, // software read descriptor
    input wire logic [IDX_W-1:0] tr_idx, // translation read entry
    output logic [BASE_W-1:0] tr_base, // translation base
    output logic [DESC_W-1:0] tr_desc // translation descriptor
);
    logic [BASE_W-1:0] base_reg [NENT];
    logic [DESC_W-1:0] desc_reg [NENT];

    ////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < NENT; i++) begin : g_ent
            wire logic hit = (wr_idx == IDX_W'(i));
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    base_reg[i] <= '0;
                    desc_reg[i] <= '0;
                end else begin
                    if (wr_base && hit)
                        base_reg[i] <= wr_data[BASE_W-1:0];
                    if (wr_desc && hit)
                        desc_reg[i] <= wr_data & DESC_WMASK;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // a write in the same cycle as a read returns the old contents
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_base <= '0;
            sw_desc <= '0;
            tr_base <= '0;
            tr_desc <= '0;
        end else begin
            sw_base <= base_reg[sw_idx];
            sw_desc <= desc_reg[sw_idx];
            tr_base <= base_reg[tr_idx];
            tr_desc <= desc_reg[tr_idx];
        end
    end
endmodule
`default_nettype wire

// ==== page_check.sv ====
// combinational relocation and access check for one page reference
// assumes its inputs come from registers of the same clock
`timescale 1ns/100ps
`default_nettype none
module page_check
    import relocation_pkg::*;
(
    input wire logic [BASE_W-1:0] base, // page base field
    input wire logic [DESC_W-1:0] desc, // page descriptor
    input wire logic [VA_W-1:0] vaddr, // virtual address
    input wire logic write, // reference modifies memory
    input wire logic mode_ok, // mode code legal
    output logic [PA_W-1:0] paddr, // relocated address
    output logic [CAUSE_W-1:0] cause // abort causes
);
    wire logic [1:0] key = desc[KEY_LO+1:KEY_LO];
    wire logic ed = desc[ED_BIT];
    wire logic [BLK_W-1:0] len = desc[LEN_LO+BLK_W-1:LEN_LO];
    wire logic [BLK_W-1:0] blk = vaddr[DISP_W-1:BLK_SHIFT];
    wire logic [PA_W-1:0] base_sh = {base, BLK_SHIFT'(0)};
    wire logic [PA_W-1:0] disp = PA_W'(vaddr[DISP_W-1:0]);

    ////////////////////////////////////////////////////////////////
    // base plus displacement
    assign paddr = base_sh + disp;
    assign cause[CAUSE_LEN] = ed ? (blk < len) : (blk > len);
    assign cause[CAUSE_NONRES] = (key == KEY_NONRES) || (key == KEY_UNUSED);
    assign cause[CAUSE_ACCESS] = (key == KEY_RO) && write;
    assign cause[CAUSE_MODE] = !mode_ok;
endmodule
`default_nettype wire

// ==== address_relocation_unit_sva.sv ====
// port checks for the address relocation unit
// assumes one clock domain, RST async active high
`timescale 1ns/100ps
`default_nettype none
module relocation_sva (
    input wire logic CLK_SYS, // clock
    input wire logic RST, // reset
    input wire logic PSEL, // select
    input wire logic PENABLE, // access
    input wire logic PWRITE, // direction
    input wire logic [11:0] PADDR, // address
    input wire logic [31:0] PWDATA, // write data
    input wire logic PSLVERR, // error
    input wire logic PREADY, // ready
    input wire relocation_pkg::cpu_req_t CPU_REQ, // reference
    input wire relocation_pkg::bus_req_t BUS_REQ, // transfer
    input wire logic ABORT, // abort
    input wire logic [8:0] TRAP_VECTOR // vector
);
    import relocation_pkg::*;
    logic en_reg;
    logic [1:0] mode;
    logic [17:0] flat;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    assign mode = CPU_REQ.use_prev ? CPU_REQ.prev_mode : CPU_REQ.cur_mode;
    assign flat = {(CPU_REQ.vaddr[15:13] == IO_PAGE) ? IO_EXT : 2'h0, CPU_REQ.vaddr};
    // shadow of the enable bit; the unit samples it at the request edge
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            en_reg <= 1'b0;
        end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_CTRL) begin
            en_reg <= PWDATA[CTRL_EN];
        end
    end
    sequence s_take;
        CPU_REQ.valid;
    endsequence
    sequence s_answer;
        BUS_REQ.valid ^ ABORT;
    endsequence
    chk_one_answer: assert property (s_take |-> ##2 s_answer)
        else $error("reference not answered once");
    chk_no_spurious: assert property (!CPU_REQ.valid |-> ##2 !(BUS_REQ.valid || ABORT))
        else $error("output without reference");
    chk_trap_vector: assert property (ABORT |-> TRAP_VECTOR == TRAP_VEC)
        else $error("wrong abort vector");
    chk_vector_idle: assert property (!ABORT |-> TRAP_VECTOR == 9'h000)
        else $error("vector without abort");
    chk_bad_mode: assert property (CPU_REQ.valid && en_reg && mode inside {2'h1, 2'h2} |-> ##2 ABORT)
        else $error("illegal mode not aborted");
    chk_off_direct: assert property (CPU_REQ.valid && !en_reg |-> ##2 BUS_REQ.valid && BUS_REQ.paddr == $past(flat, 2))
        else $error("direct address wrong");
    chk_dir_kept: assert property (BUS_REQ.valid |-> BUS_REQ.write == $past(CPU_REQ.write, 2))
        else $error("direction changed");
    chk_disp_low: assert property (BUS_REQ.valid |-> BUS_REQ.paddr[5:0] == $past(CPU_REQ.vaddr[5:0], 2))
        else $error("low displacement altered");
    chk_bad_addr: assert property (PSEL && PENABLE && PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR)
        else $error("unaligned access accepted");
endmodule
bind address_relocation_unit relocation_sva i_relocation_sva (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR), .PREADY(PREADY),
    .CPU_REQ(CPU_REQ), .BUS_REQ(BUS_REQ), .ABORT(ABORT), .TRAP_VECTOR(TRAP_VECTOR));
`default_nettype wire

// ==== cpu_core_model.sv ====
// processor core model issuing one reference per request
// assumes the bench pulses issue for one cycle
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic issue, // start a reference
    input wire relocation_pkg::cpu_req_t cmd, // fields
    output relocation_pkg::cpu_req_t req // reference bus
);
    import relocation_pkg::*;
    localparam int REQ_W = $bits(cpu_req_t);
    // idle fields toggle so the unit cannot lean on stale values
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req <= '0;
        end else if (issue) begin
            req <= cpu_req_t'({1'b1, cmd[REQ_W-2:0]});
        end else begin
            req <= cpu_req_t'({1'b0, ~req[REQ_W-2:0]});
        end
    end
endmodule
`default_nettype wire

// ==== address_relocation_unit_tb.sv ====
// self-checking bench for the address relocation unit
// assumes an apb slave that may insert wait states and two-cycle translation
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module address_relocation_unit_tb;
    import relocation_pkg::*;
    logic CLK_SYS, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, ABORT, issue, err;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [8:0] TRAP_VECTOR;
    cpu_req_t cmd, CPU_REQ;
    bus_req_t BUS_REQ;
    int num_errors = 0;
    int num_checks = 0;
    address_relocation_unit i_address_relocation_unit (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .CPU_REQ(CPU_REQ), .BUS_REQ(BUS_REQ), .ABORT(ABORT),
        .TRAP_VECTOR(TRAP_VECTOR));
    cpu_core_model i_cpu_core_model (.clk(CLK_SYS), .rst(RST), .issue(issue), .cmd(cmd), .req(CPU_REQ));
    initial begin
        CLK_SYS = 1'b0;
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic xlat(input logic [1:0] cm, pm, input logic up, w, input logic [15:0] va,
        input logic ab, input logic [17:0] pa);
        @(posedge CLK_SYS);
        cmd <= '{1'b1, w, cm, pm, up, va};
        issue <= 1'b1;
        @(posedge CLK_SYS);
        issue <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        #1;
        `CHK("abort", {ab, ~ab}, {ABORT, BUS_REQ.valid})
        if (ab) `CHK("vector", TRAP_VEC, TRAP_VECTOR)
        else `CHK("paddr", {w, pa}, {BUS_REQ.write, BUS_REQ.paddr})
    endtask
    initial begin
        RST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = '0;
        PWDATA = '0;
        issue = 1'b0;
        cmd = '0;
        repeat (20) @(posedge CLK_SYS);
        RST <= 1'b0;
        apb(0, 12'h004, '0);
        `CHK("base rst", 32'h0, rd)
        apb(1, 12'h004, 32'hffff_ffff);
        apb(0, 12'h004, '0);
        `CHK("base", 32'h0000_0fff, rd)
        apb(1, 12'h044, 32'hffff_ffff);
        apb(0, 12'h044, '0);
        `CHK("desc", 32'h0000_7f0e, rd)
        apb(0, 12'h0f0, '0);
        `CHK("unmapped", 1'b1, err)
        apb(0, 12'h002, '0);
        `CHK("unaligned", 1'b1, err)
        $display("test registers done");
        xlat(2'h1, 2'h0, 0, 1, 16'he000, 0, 18'h3e000);
        xlat(2'h0, 2'h0, 0, 0, 16'h1234, 0, 18'h01234);
        $display("test direct done");
        apb(1, OFS_CTRL, 32'h1);
        apb(0, OFS_CTRL, '0);
        `CHK("ctrl", 32'h0000_0001, rd)
        apb(1, 12'h004, 32'h0a0);
        apb(1, 12'h044, 32'h7f06);
        apb(1, 12'h024, 32'h010);
        apb(1, 12'h064, 32'h7f02);
        apb(1, 12'h04c, 32'h7f04);
        apb(1, 12'h010, 32'h100);
        apb(1, 12'h050, 32'h0206);
        apb(1, 12'h054, 32'h020e);
        xlat(2'h0, 2'h3, 0, 1, 16'h2040, 0, 18'h02840);
        xlat(2'h0, 2'h0, 0, 0, 16'h3fff, 0, 18'h047ff);
        xlat(2'h3, 2'h0, 0, 0, 16'h2000, 0, 18'h00400);
        xlat(2'h3, 2'h0, 0, 1, 16'h2000, 1, 18'h0);
        xlat(2'h0, 2'h3, 1, 0, 16'h2010, 0, 18'h00410);
        xlat(2'h0, 2'h3, 1, 1, 16'h2010, 1, 18'h0);
        xlat(2'h3, 2'h0, 0, 0, 16'h8000, 1, 18'h0);
        xlat(2'h0, 2'h0, 0, 0, 16'h0000, 1, 18'h0);
        xlat(2'h0, 2'h0, 0, 0, 16'h6000, 1, 18'h0);
        xlat(2'h1, 2'h0, 0, 0, 16'h2040, 1, 18'h0);
        xlat(2'h2, 2'h0, 0, 0, 16'h2040, 1, 18'h0);
        xlat(2'h0, 2'h0, 0, 0, 16'h80bf, 0, 18'h040bf);
        xlat(2'h0, 2'h0, 0, 0, 16'h80c0, 1, 18'h0);
        xlat(2'h0, 2'h0, 0, 0, 16'ha03f, 1, 18'h0);
        xlat(2'h0, 2'h0, 0, 1, 16'ha080, 0, 18'h00080);
        $display("test relocation done");
        apb(0, OFS_STAT, '0);
        `CHK("stat", 32'h0000_005f, rd)
        apb(1, OFS_STAT, 32'h0000_0005);
        apb(0, OFS_STAT, '0);
        `CHK("stat clr", 32'h0000_005a, rd)
        $display("test status done");
        final_report();
    end
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
